// [hw/rpsc_top.sv]
// reset sampling, internal reset and idle / power-down control
// Functional notes
// - reset pin sampled at state5 phase2
// - ports keep activity 19 osc periods
// - internal reset clears registers except listed
// - ports to ones, stack pointer seven
// - internal RAM untouched by reset
// - pc, data_pointer zero; ip, ie partly undefined
// - ports undefined until reset writes ones
// - idle bit gates cpu clock only
// - idle keeps state, strobes held high
// - enabled interrupt clears idle bit
// - two general flags readable and writable
// - reset pin clears idle bit directly
// - RAM blocked until internal reset ends
// - power-down bit stops oscillator, strobes high
// - reset restarts oscillator, waits to stabilise
// - external clock divided by two
module rpsc_top #(
   parameter int unsigned OSC_RESTART_CYCLES = rpsc_pkg::OSC_RESTART_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        reset_pin,
   input  wire logic        ext_clock_mode,
   input  wire logic        instr_done,
   input  wire logic        irq_wake,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             internal_reset,
   output logic [15:0]      program_counter_init,
   output logic [15:0]      data_pointer_init,
   output logic             cpu_clock_enable,
   output logic             periph_clock_enable,
   output logic             osc_running,
   output logic             strobes_force_high,
   output logic             ram_access_enable,
   output logic [31:0]      port_pins_out,
   output logic [31:0]      port_pins_oe,
   output rpsc_pkg::rpsc_state_e seq_state
);
   import rpsc_pkg::*;

   rpsc_state_e state;
   rpsc_state_e next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [7:0]       power_control_register;
   logic [7:0]       port_latch [NUM_PORTS];
   logic [7:0]       stack_pointer;
   logic [7:0]       interrupt_priority_register;
   logic [7:0]       interrupt_enable_register;
   logic             idle_mode;
   logic             pd_mode;
   logic             ram_block;
   logic             ports_valid;
   logic             pin_sync;
   logic             osc_tick;
   logic             sample_tick;
   logic [3:0]       slot;
   logic [7:0]       rdata_next;

   // decode of the register port
   wire              wr_power_control   = reg_wr && (reg_addr == OFF_POWER_CONTROL);
   wire              wr_sp     = reg_wr && (reg_addr == OFF_STACK_POINTER);
   wire              wr_ip     = reg_wr && (reg_addr == OFF_INT_PRIORITY);
   wire              wr_ie     = reg_wr && (reg_addr == OFF_INT_ENABLE);
   wire              sreset    = (state == RPSC_IRESET);
   wire              idle_bit  = power_control_register[POWER_CONTROL_IDLE];
   wire              pd_bit    = power_control_register[POWER_CONTROL_PD];
   wire [CNT_W-1:0]  hold_last = CNT_W'(PORT_HOLD_OSC - 1);
   wire [CNT_W-1:0]  rest_last = CNT_W'(OSC_RESTART_CYCLES - 1);
   wire              restart_done = (cnt == rest_last);
   wire              hold_done    = osc_tick && (cnt == hold_last);

   // reset pin passes two flops before use
   rpsc_sync u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .pin_in   (reset_pin),
      .pin_sync (pin_sync)
   );

   // oscillator stops in power-down only and runs while restarting
   assign osc_running = (state != RPSC_PDOWN);

   // machine-cycle timing with optional divide-by-two
   rpsc_timing u_timing (
      .clock       (clock),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .osc_run     (osc_running),
      .div2_mode   (ext_clock_mode),
      .osc_tick    (osc_tick),
      .sample_tick (sample_tick),
      .slot        (slot)
   );

   // sequencer next-state logic
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         RPSC_RUN: begin
            if (sample_tick && pin_sync) begin
               next_state = RPSC_HOLD;
               next_cnt   = '0;
            end else if (pd_mode) begin
               next_state = RPSC_PDOWN;
            end
         end
         RPSC_HOLD: begin
            // ports keep running for a fixed count
            if (hold_done) begin
               next_state = RPSC_IRESET;
            end else if (osc_tick) begin
               next_cnt = cnt + CNT_W'(1);
            end
         end
         RPSC_IRESET: begin
            if (sample_tick && !pin_sync) begin
               next_state = RPSC_RUN;
            end
         end
         RPSC_PDOWN: begin
            if (pin_sync) begin
               next_state = RPSC_RESTART;
               next_cnt   = '0;
            end
         end
         RPSC_RESTART: begin
            // wait for the oscillator to settle
            if (!pin_sync) begin
               next_state = RPSC_PDOWN;
            end else if (restart_done) begin
               next_state = RPSC_HOLD;
               next_cnt   = '0;
            end else begin
               next_cnt = cnt + CNT_W'(1);
            end
         end
         default: begin
            next_state = RPSC_RUN;
            next_cnt   = '0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= RPSC_RUN;
         cnt   <= '0;
      end else if (clk_en) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // power control register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         power_control_register <= POWER_CONTROL_RST;
      end else if (clk_en) begin
         if (sreset) begin
            power_control_register <= POWER_CONTROL_RST;
         end else begin
            if (wr_power_control) begin
               power_control_register <= reg_wdata & POWER_CONTROL_MASK;
            end
            if (pin_sync || (irq_wake && idle_mode)) begin
               power_control_register[POWER_CONTROL_IDLE] <= 1'b0;
            end
         end
      end
   end

   // mode entry waits for the setting instruction to finish
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         idle_mode <= 1'b0;
         pd_mode   <= 1'b0;
      end else if (clk_en) begin
         idle_mode <= idle_bit && (idle_mode || instr_done);
         pd_mode   <= pd_bit && (pd_mode || instr_done);
      end
   end

   // clock gating and strobe hold
   assign periph_clock_enable = osc_running && (state != RPSC_RESTART);
   assign cpu_clock_enable    = periph_clock_enable && !idle_mode && !pd_mode;
   assign strobes_force_high  = idle_mode || pd_mode;

   // RAM blocked from reset-induced idle exit to internal reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ram_block <= 1'b0;
      end else if (clk_en) begin
         if (sreset) begin
            ram_block <= 1'b0;
         end else if (idle_mode && pin_sync) begin
            ram_block <= 1'b1;
         end
      end
   end

   // RAM is never cleared, only gated
   assign ram_access_enable = !ram_block && !sreset;

   // vectors loaded during internal reset
   assign internal_reset       = sreset;
   assign program_counter_init = PC_RST;
   assign data_pointer_init    = DATA_POINTER_RST;

   // ports undefined until the first internal reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ports_valid <= 1'b0;
      end else if (clk_en && sreset) begin
         ports_valid <= 1'b1;
      end
   end

   // port latches, one per port
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         wire wr_port = reg_wr && (reg_addr == OFF_PORT_BASE + 8'(gp));
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               port_latch[gp] <= PORT_RST;
            end else if (clk_en) begin
               if (sreset) begin
                  port_latch[gp] <= PORT_RST;
               end else if (wr_port) begin
                  port_latch[gp] <= reg_wdata;
               end
            end
         end
         assign port_pins_out[gp*8 +: 8] = port_latch[gp];
         assign port_pins_oe[gp*8 +: 8]  = {8{ports_valid}};
      end
   endgenerate

   // stack pointer and interrupt registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stack_pointer               <= SP_RST;
         interrupt_priority_register <= IP_RST;
         interrupt_enable_register   <= IE_RST;
      end else if (clk_en) begin
         if (sreset) begin
            stack_pointer               <= SP_RST;
            interrupt_priority_register <= IP_RST;
            interrupt_enable_register   <= IE_RST;
         end else begin
            if (wr_sp) begin
               stack_pointer <= reg_wdata;
            end
            if (wr_ip) begin
               interrupt_priority_register <= reg_wdata & IP_MASK;
            end
            if (wr_ie) begin
               interrupt_enable_register <= reg_wdata & IE_MASK;
            end
         end
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      rdata_next = ZERO8;
      case (reg_addr)
         OFF_POWER_CONTROL: rdata_next = power_control_register;
         OFF_STACK_POINTER: rdata_next = stack_pointer;
         OFF_INT_PRIORITY:  rdata_next = interrupt_priority_register;
         OFF_INT_ENABLE:    rdata_next = interrupt_enable_register;
         OFF_STATUS:        rdata_next = {ram_block, ports_valid, pd_mode, idle_mode, slot};
         default: begin
            if (reg_addr >= OFF_PORT_BASE && reg_addr < OFF_PORT_BASE + 8'(NUM_PORTS)) begin
               rdata_next = port_latch[2'(reg_addr - OFF_PORT_BASE)];
            end
         end
      endcase
   end

   // read data stands one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= ZERO8;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_next : ZERO8;
      end
   end

   assign seq_state = state;
endmodule

// [hw/rpsc_pkg.sv]
// constants for the reset and power-saving sequencer
package rpsc_pkg;
   // clock and oscillator timing
   localparam int unsigned CLOCK_MHZ         = 250;
   localparam int unsigned OSC_PER_MCYCLE    = 12;
   localparam int unsigned STATES_PER_MCYCLE = 6;
   localparam int unsigned PHASES_PER_STATE  = 2;
   localparam int unsigned SAMPLE_STATE      = 5;
   localparam int unsigned SAMPLE_PHASE      = 2;
   localparam logic [3:0]  SAMPLE_SLOT       = 4'((SAMPLE_STATE - 1) * PHASES_PER_STATE + SAMPLE_PHASE - 1);
   localparam logic [3:0]  LAST_SLOT         = 4'(OSC_PER_MCYCLE - 1);
   localparam int unsigned PORT_HOLD_OSC     = 19;
   localparam int unsigned OSC_RESTART_US    = 10000;
   localparam int unsigned OSC_RESTART_CYC   = OSC_RESTART_US * CLOCK_MHZ;
   localparam int unsigned CNT_W             = 24;

   // register offsets on the plain register port
   localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;
   localparam logic [7:0] OFF_PORT_BASE     = 8'h01;
   localparam logic [7:0] OFF_STACK_POINTER = 8'h05;
   localparam logic [7:0] OFF_INT_PRIORITY  = 8'h06;
   localparam logic [7:0] OFF_INT_ENABLE    = 8'h07;
   localparam logic [7:0] OFF_STATUS        = 8'h08;
   localparam int unsigned NUM_PORTS        = 4;

   // power control field positions
   localparam int unsigned POWER_CONTROL_IDLE = 0;
   localparam int unsigned POWER_CONTROL_PD   = 1;
   localparam int unsigned POWER_CONTROL_GF0  = 2;
   localparam int unsigned POWER_CONTROL_GF1  = 3;
   localparam logic [7:0]  POWER_CONTROL_MASK = 8'h8f;

   // reset values applied by the internal reset sequence
   localparam logic [7:0]  POWER_CONTROL_RST  = 8'h00;
   localparam logic [7:0]  PORT_RST  = 8'hff;
   localparam logic [7:0]  SP_RST    = 8'h07;
   localparam logic [7:0]  IP_RST    = 8'h00;
   localparam logic [7:0]  IP_MASK   = 8'h3f;
   localparam logic [7:0]  IE_RST    = 8'h00;
   localparam logic [7:0]  IE_MASK   = 8'hbf;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [15:0] DATA_POINTER_RST  = 16'h0000;
   localparam logic [7:0]  ZERO8     = 8'h00;

   // sequencer states
   typedef enum logic [4:0] {
      RPSC_RUN     = 5'b00001,
      RPSC_HOLD    = 5'b00010,
      RPSC_IRESET  = 5'b00100,
      RPSC_PDOWN   = 5'b01000,
      RPSC_RESTART = 5'b10000
   } rpsc_state_e;
endpackage

// [hw/rpsc_sync.sv]
// two-stage synchroniser for the asynchronous reset pin
module rpsc_sync (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      pin_sync
);
   import rpsc_pkg::*;

   logic meta;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta     <= 1'b0;
         pin_sync <= 1'b0;
      end else if (clk_en) begin
         meta     <= pin_in;
         pin_sync <= meta;
      end
   end
endmodule

// [hw/rpsc_timing.sv]
// oscillator divider and machine-cycle slot counter
module rpsc_timing (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       osc_run,
   input  wire logic       div2_mode,
   output logic            osc_tick,
   output logic            sample_tick,
   output logic [3:0]      slot
);
   import rpsc_pkg::*;

   logic half;

   // one oscillator period per clock, or every second clock
   assign osc_tick    = osc_run && (!div2_mode || half);
   assign sample_tick = osc_tick && (slot == SAMPLE_SLOT);

   // divide-by-two flop and slot count within a machine cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         half <= 1'b0;
         slot <= 4'h0;
      end else if (clk_en && osc_run) begin
         half <= !half;
         if (osc_tick) begin
            slot <= (slot == LAST_SLOT) ? 4'h0 : slot + 4'h1;
         end
      end
   end
endmodule

// [verification/rpsc_monitor.sv]
// assertion checker on the ports of the reset and power-saving sequencer
module rpsc_monitor
   import rpsc_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire logic                  reset_pin,
   input wire logic                  irq_wake,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  internal_reset,
   input wire logic [15:0]           program_counter_init,
   input wire logic [15:0]           data_pointer_init,
   input wire logic                  cpu_clock_enable,
   input wire logic                  periph_clock_enable,
   input wire logic                  osc_running,
   input wire logic                  strobes_force_high,
   input wire logic                  ram_access_enable,
   input wire logic [31:0]           port_pins_out,
   input wire rpsc_pkg::rpsc_state_e seq_state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_n);
   // state decodes shared by the properties
   logic pd;
   logic run;
   assign pd  = (seq_state == RPSC_PDOWN);
   assign run = (seq_state == RPSC_RUN);

   read_data_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data present outside its cycle");
   reset_ram_block_a: assert property (internal_reset |-> !ram_access_enable)
      else $error("ram open during internal reset");
   reset_ports_high_a: assert property (internal_reset |=> port_pins_out == 32'hffffffff)
      else $error("port latches not set by internal reset");
   pd_stop_a: assert property (pd |-> !osc_running && !cpu_clock_enable && strobes_force_high)
      else $error("power-down outputs wrong");
   restart_clock_a: assert property ($rose(seq_state == RPSC_RESTART) |-> osc_running && !periph_clock_enable)
      else $error("restart did not free the oscillator or gate the clocks");
   load_zero_a: assert property (program_counter_init == 16'h0000 && data_pointer_init == 16'h0000)
      else $error("load values not zero");
   hold_ports_a: assert property ($rose(seq_state == RPSC_HOLD) |-> ($stable(port_pins_out) && !internal_reset)[*8])
      else $error("ports changed during hold");
   hold_time_a: assert property ($rose(seq_state == RPSC_HOLD) |-> ##[18:80] internal_reset)
      else $error("hold did not end in internal reset");
   idle_wake_a: assert property (strobes_force_high && run && irq_wake |-> ##[1:2] cpu_clock_enable)
      else $error("interrupt did not end idle");
   pin_idle_exit_a: assert property (strobes_force_high && run && reset_pin |-> ##[1:5] cpu_clock_enable)
      else $error("reset pin did not end idle");
   idle_periph_a: assert property (!cpu_clock_enable && run |-> periph_clock_enable)
      else $error("peripheral clock lost in idle");
   pd_stays_a: assert property (pd && !reset_pin && !$past(reset_pin) && !$past(reset_pin, 2) |=> pd)
      else $error("power-down left without reset");

   cover property ($rose(internal_reset));
   cover property (pd && irq_wake);
   cover property (strobes_force_high && run && irq_wake);
   cover property ($rose(seq_state == RPSC_RESTART));
endmodule

// [verification/rpsc_partner.sv]
// far-side model: external reset source and cpu core strobes
module rpsc_partner (
   input  wire logic clock,
   output logic      reset_pin,
   output logic      instr_done,
   output logic      irq_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins idle low from time zero
   initial begin
      reset_pin = 1'b0;
      instr_done = 1'b0;
      irq_wake = 1'b0;
   end
   // reset held n clocks; callers never go under 24 osc periods
   task automatic pin_pulse(input int n);
      reset_pin <= 1'b1;
      repeat (n) @(posedge clock);
      reset_pin <= 1'b0;
   endtask
   // instruction end; the next one never writes a port
   task automatic finish_instr();
      instr_done <= 1'b1;
      @(posedge clock);
      instr_done <= 1'b0;
   endtask
   // one-cycle enabled interrupt
   task automatic wake();
      irq_wake <= 1'b1;
      @(posedge clock);
      irq_wake <= 1'b0;
   endtask
endmodule

// [verification/rpsc_top_tb_top.sv]
// self-checking bench for the reset and power-saving sequencer
module rpsc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rpsc_pkg::*;
   logic        clock, rst_n, clk_en, ext_clock_mode, reg_wr, reg_rd;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   logic        reset_pin, instr_done, irq_wake, internal_reset, osc_running;
   logic        cpu_clock_enable, periph_clock_enable, strobes_force_high, ram_access_enable;
   logic [15:0] program_counter_init, data_pointer_init;
   logic [31:0] port_pins_out, port_pins_oe;
   rpsc_state_e seq_state;
   int          failures, cmp_count;

   rpsc_top #(.OSC_RESTART_CYCLES(20)) DUT (.clock, .rst_n, .clk_en, .reset_pin, .ext_clock_mode,
      .instr_done, .irq_wake, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_reset,
      .program_counter_init, .data_pointer_init, .cpu_clock_enable, .periph_clock_enable,
      .osc_running, .strobes_force_high, .ram_access_enable, .port_pins_out, .port_pins_oe, .seq_state);
   rpsc_partner far (.clock, .reset_pin, .instr_done, .irq_wake);

   // 250 MHz clock
   initial clock = 1'b0;
   always #2 clock = ~clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one register cycle; read data taken in the cycle after the strobe
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clock);
      if (!w) check(reg_rdata, exp);
   endtask
   // bounded wait for the internal reset level
   task automatic wait_for(input logic lvl);
      int n;
      n = 0;
      while (internal_reset !== lvl && n < 200) begin
         @(posedge clock);
         n++;
      end
      check(internal_reset, lvl);
   endtask
   task automatic chk_defaults();
      bus(0, OFF_POWER_CONTROL, 8'h00, 8'h00);
      for (int i = 0; i < NUM_PORTS; i++) bus(0, OFF_PORT_BASE + 8'(i), 8'h00, 8'hff);
      bus(0, OFF_STACK_POINTER, 8'h00, 8'h07);
      bus(0, OFF_INT_PRIORITY, 8'h00, 8'h00);
      bus(0, OFF_INT_ENABLE, 8'h00, 8'h00);
      bus(0, 8'h40, 8'h00, 8'h00);
   endtask

   // watchdog at 12500 cycles: the tests need a few hundred cycles
   initial begin
      #50us;
      failures++;
      print_verdict();
   end

   initial begin
      {rst_n, ext_clock_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      clk_en = 1'b1;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      void'($urandom(20025));
      chk_defaults();
      check(port_pins_oe, 32'h0);
      $display("test power-on values done");
      // random register traffic, undefined bits read as zero
      repeat (8) begin
         v = 8'($urandom);
         bus(1, OFF_POWER_CONTROL, v & 8'h8c, 8'h00);
         bus(0, OFF_POWER_CONTROL, 8'h00, v & 8'h8c);
         bus(1, OFF_INT_PRIORITY, v, 8'h00);
         bus(0, OFF_INT_PRIORITY, 8'h00, v & 8'h3f);
         bus(1, OFF_INT_ENABLE, v, 8'h00);
         bus(0, OFF_INT_ENABLE, 8'h00, v & 8'hbf);
         bus(1, OFF_STACK_POINTER, v, 8'h00);
         // a write while the clock enable is low must not land
         clk_en <= 1'b0;
         bus(1, OFF_STACK_POINTER, ~v, 8'h00);
         clk_en <= 1'b1;
         bus(0, OFF_STACK_POINTER, 8'h00, v);
         bus(1, OFF_PORT_BASE, ~v, 8'h00);
         bus(0, OFF_PORT_BASE, 8'h00, ~v);
         check(port_pins_out[7:0], 8'(~v));
      end
      $display("test register access done");
      // pin reset with and without the divide-by-two
      for (int m = 0; m < 2; m++) begin
         ext_clock_mode <= m[0];
         bus(1, OFF_POWER_CONTROL, 8'h0c, 8'h00);
         far.pin_pulse(30 * (m + 1));
         wait_for(1'b1);
         wait_for(1'b0);
         chk_defaults();
         check(port_pins_oe, 32'hffffffff);
      end
      ext_clock_mode <= 1'b0;
      $display("test reset pin done");
      // idle entry and interrupt exit
      bus(1, OFF_POWER_CONTROL, 8'h05, 8'h00);
      far.finish_instr();
      @(posedge clock);
      check({cpu_clock_enable, periph_clock_enable, strobes_force_high}, 3'b011);
      far.wake();
      repeat (2) @(posedge clock);
      check(cpu_clock_enable, 1'b1);
      bus(0, OFF_POWER_CONTROL, 8'h00, 8'h04);
      $display("test idle wake done");
      // idle exit through the reset pin
      bus(1, OFF_POWER_CONTROL, 8'h01, 8'h00);
      far.finish_instr();
      fork
         far.pin_pulse(30);
      join_none
      repeat (5) @(posedge clock);
      check({cpu_clock_enable, ram_access_enable, internal_reset}, 3'b100);
      wait_for(1'b1);
      wait_for(1'b0);
      check(ram_access_enable, 1'b1);
      $display("test idle reset exit done");
      // power-down, refused wake, reset exit
      bus(1, OFF_POWER_CONTROL, 8'h02, 8'h00);
      far.finish_instr();
      repeat (2) @(posedge clock);
      check({seq_state, osc_running}, {RPSC_PDOWN, 1'b0});
      far.wake();
      repeat (3) @(posedge clock);
      check(seq_state, RPSC_PDOWN);
      fork
         far.pin_pulse(80);
      join_none
      wait_for(1'b1);
      check(osc_running, 1'b1);
      wait_for(1'b0);
      bus(0, OFF_POWER_CONTROL, 8'h00, 8'h00);
      $display("test power-down done");
      print_verdict();
   end
endmodule

bind rpsc_top rpsc_monitor mon (.clock, .rst_n, .reset_pin, .irq_wake, .reg_rd, .reg_rdata, .internal_reset,
   .program_counter_init, .data_pointer_init, .cpu_clock_enable, .periph_clock_enable, .osc_running,
   .strobes_force_high, .ram_access_enable, .port_pins_out, .seq_state);
